// >>> thermo_sensor_i2c_slave_port.sv
// Purpose: target side of the two-wire serial port of a temperature converter
// Assumes: REF_CLK 50 MHz, pins sampled through two flops
// Notes: open-drain pins, enables low while pulling the line low
`timescale 1ns/10ps
`include "thermo_port_cfg.svh"
module thermo_sensor_i2c_slave_port
    import thermo_port_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE_N,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    input wire logic [2:0] ADDR_LEVEL,
    output logic RD_REQ,
    output logic [5:0] RD_PTR,
    input wire logic [7:0] RD_DATA,
    input wire logic RD_VALID,
    output logic WR_VALID,
    input wire logic WR_READY,
    output logic [5:0] WR_PTR,
    output logic [7:0] WR_DATA,
    output logic BUSY
);
    localparam logic [11:0] STRETCH_LAST = 12'(`STRETCH_CYC - 1);
    localparam logic [11:0] SETUP_LAST = 12'(`SETUP_CYC - 1);
    localparam logic [11:0] LOAD_LAST = 12'(`STRETCH_CYC - 1 - `SETUP_CYC);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic scl_m, scl_s, scl_d;
    logic sda_m, sda_s, sda_d;
    logic [2:0] lvl_m, lvl_s;

    // Two flops per pin, then a delay stage for edges
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
            lvl_m <= 3'h0;
            lvl_s <= 3'h0;
        end else begin
            scl_m <= SCL_IN;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= SDA_IN;
            sda_s <= sda_m;
            sda_d <= sda_s;
            lvl_m <= ADDR_LEVEL;
            lvl_s <= lvl_m;
        end
    end

    logic scl_rise, scl_fall, start_seen, stop_seen;
    logic [6:0] my_addr;

    // Bus events and own address
    always_comb begin
        scl_rise = scl_s && !scl_d;
        scl_fall = !scl_s && scl_d;
        start_seen = scl_s && scl_d && sda_d && !sda_s;
        stop_seen = scl_s && scl_d && !sda_d && sda_s;
        my_addr = {`ADDR_FIXED, lvl_s};
    end

    // ----------------------------------------
    // Transfer state
    // ----------------------------------------
    port_state_t st, next_st;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shreg, next_shreg;
    logic [7:0] tx, next_tx;
    logic [7:0] pend, next_pend;
    logic pend_ok, next_pend_ok;
    logic [5:0] ptr, next_ptr;
    logic first_wr, next_first_wr;
    logic acked, next_acked;
    logic sda_drv, next_sda_drv;
    logic scl_hold, next_scl_hold;
    logic [11:0] str_cnt, next_str_cnt;
    logic rd_req, next_rd_req;
    logic wr_push, next_wr_push;
    logic [7:0] wr_byte, next_wr_byte;
    logic fifo_ready;

    // Pointer step with wrap inside six bits
    function automatic logic [5:0] ptr_step(input logic [5:0] p);
        ptr_step = p + 6'h01;
    endfunction

    // Next values of the transfer machine
    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_shreg = shreg;
        next_tx = tx;
        next_pend = pend;
        next_pend_ok = pend_ok;
        next_ptr = ptr;
        next_first_wr = first_wr;
        next_acked = acked;
        next_sda_drv = sda_drv;
        next_scl_hold = scl_hold;
        next_str_cnt = str_cnt;
        next_rd_req = 1'b0;
        next_wr_push = wr_push;
        next_wr_byte = wr_byte;
        if (RD_VALID && st == ST_RD_STRETCH) begin
            next_pend = RD_DATA;
            next_pend_ok = 1'b1;
        end
        if (start_seen) begin
            next_st = ST_ADDR;
            next_cnt = 4'h0;
            next_sda_drv = 1'b0;
            next_scl_hold = 1'b0;
            next_wr_push = 1'b0;
        end else if (stop_seen) begin
            next_st = ST_IDLE;
            next_sda_drv = 1'b0;
            next_scl_hold = 1'b0;
            next_wr_push = 1'b0;
        end else begin
            case (st)
                ST_IDLE: begin
                    next_sda_drv = 1'b0;
                end
                ST_ADDR, ST_WR_BYTE: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_s};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == `BIT_LAST) begin
                        if (st == ST_ADDR) begin
                            if (shreg[7:1] == my_addr) begin
                                next_sda_drv = 1'b1;
                                next_st = ST_ADDR_ACK;
                                next_acked = shreg[0];
                                next_first_wr = 1'b1;
                            end else begin
                                next_st = ST_IDLE;
                            end
                        end else if (first_wr) begin
                            next_ptr = shreg[5:0];
                            next_first_wr = 1'b0;
                            next_sda_drv = 1'b1;
                            next_st = ST_WR_ACK;
                        end else begin
                            next_wr_byte = shreg;
                            next_wr_push = 1'b1;
                            next_scl_hold = 1'b1;
                            next_st = ST_WR_WAIT;
                        end
                    end
                end
                ST_WR_WAIT: begin
                    next_str_cnt = 12'h000;
                    if (fifo_ready) begin
                        next_wr_push = 1'b0;
                        next_sda_drv = 1'b1;
                        next_st = ST_WR_ACK;
                    end
                end
                ST_ADDR_ACK, ST_WR_ACK: begin
                    if (scl_hold) begin
                        // Acknowledge settles before the held clock is let go
                        next_str_cnt = str_cnt + 12'h001;
                        if (str_cnt == SETUP_LAST) begin
                            next_scl_hold = 1'b0;
                        end
                    end else if (scl_fall) begin
                        next_sda_drv = 1'b0;
                        next_cnt = 4'h0;
                        if (st == ST_ADDR_ACK && acked) begin
                            next_st = ST_RD_STRETCH;
                            next_scl_hold = 1'b1;
                            next_str_cnt = 12'h000;
                            next_rd_req = 1'b1;
                            next_pend_ok = 1'b0;
                            next_sda_drv = !tx[7];
                        end else begin
                            next_st = ST_WR_BYTE;
                        end
                    end
                end
                ST_RD_STRETCH: begin
                    next_str_cnt = str_cnt + 12'h001;
                    if (scl_rise) begin
                        next_scl_hold = 1'b0;
                        next_st = ST_RD_BYTE;
                    end else if (str_cnt == LOAD_LAST) begin
                        // New MSB set up a setup time before the clock is let go
                        if (pend_ok || RD_VALID) begin
                            next_tx = pend_ok ? pend : RD_DATA;
                            next_sda_drv = pend_ok ? !pend[7] : !RD_DATA[7];
                        end
                    end else if (str_cnt == STRETCH_LAST) begin
                        next_scl_hold = 1'b0;
                        next_st = ST_RD_BYTE;
                    end
                end
                ST_RD_BYTE: begin
                    if (scl_fall) begin
                        if (cnt == 4'h7) begin
                            next_sda_drv = 1'b0;
                            next_st = ST_RD_ACK;
                        end else begin
                            next_cnt = cnt + 4'h1;
                            next_sda_drv = !tx[6 - cnt[2:0]];
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        next_acked = !sda_s;
                    end else if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (acked) begin
                            next_ptr = ptr_step(ptr);
                            next_st = ST_RD_STRETCH;
                            next_scl_hold = 1'b1;
                            next_str_cnt = 12'h000;
                            next_rd_req = 1'b1;
                            next_pend_ok = 1'b0;
                            next_sda_drv = !tx[7];
                        end else begin
                            next_st = ST_IDLE;
                        end
                    end
                end
                default: begin
                    next_st = ST_IDLE;
                    next_sda_drv = 1'b0;
                    next_scl_hold = 1'b0;
                end
            endcase
        end
    end

    // Transfer registers
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st <= ST_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            tx <= 8'hff;
            pend <= 8'h00;
            pend_ok <= 1'b0;
            ptr <= `PTR_RESET;
            first_wr <= 1'b0;
            acked <= 1'b0;
            sda_drv <= 1'b0;
            scl_hold <= 1'b0;
            str_cnt <= 12'h000;
            rd_req <= 1'b0;
            wr_push <= 1'b0;
            wr_byte <= 8'h00;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            shreg <= next_shreg;
            tx <= next_tx;
            pend <= next_pend;
            pend_ok <= next_pend_ok;
            ptr <= next_ptr;
            first_wr <= next_first_wr;
            acked <= next_acked;
            sda_drv <= next_sda_drv;
            scl_hold <= next_scl_hold;
            str_cnt <= next_str_cnt;
            rd_req <= next_rd_req;
            wr_push <= next_wr_push;
            wr_byte <= next_wr_byte;
        end
    end

    // ----------------------------------------
    // Write buffer toward the register file
    // ----------------------------------------
    logic [13:0] fifo_out;

    byte_fifo #(
        .WIDTH(`FIFO_W),
        .DEPTH(`FIFO_D)
    ) u_fifo (
        .clk(REF_CLK),
        .rst_n(ARST_N),
        .in_valid(wr_push),
        .in_ready(fifo_ready),
        .in_data({ptr, wr_byte}),
        .out_valid(WR_VALID),
        .out_ready(WR_READY),
        .out_data(fifo_out)
    );

    // Pin and side outputs; lines only ever pulled low
    always_comb begin
        SDA_OUT = 1'b0;
        SCL_OUT = 1'b0;
        SDA_OE_N = !sda_drv;
        SCL_OE_N = !scl_hold;
        WR_PTR = fifo_out[13:8];
        WR_DATA = fifo_out[7:0];
        RD_REQ = rd_req;
        RD_PTR = ptr;
        BUSY = (st != ST_IDLE);
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_start_release : assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        start_seen |=> (st == ST_ADDR && SDA_OE_N && SCL_OE_N))
        else $error("start did not release the bus");
    chk_stop_idle : assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        stop_seen |=> (st == ST_IDLE && SDA_OE_N))
        else $error("stop did not end the transfer");
    chk_addr_match : assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (st == ST_ADDR && !start_seen && !stop_seen && scl_fall && cnt == `BIT_LAST)
        |=> (!SDA_OE_N == ($past(shreg[7:1]) == {4'hc, $past(lvl_s)})))
        else $error("address acknowledge disagrees with match");
    chk_dir_bit : assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (st == ST_ADDR_ACK && acked && scl_fall && !start_seen && !stop_seen)
        |=> (st == ST_RD_STRETCH && RD_REQ))
        else $error("read bit did not start a read");
    chk_stretch_held : assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (st == ST_RD_STRETCH && str_cnt < STRETCH_LAST && !scl_rise) |=> !SCL_OE_N)
        else $error("clock released early during stretch");
    logic [12:0] hold_age, next_hold_age;

    // Age of the current read stretch, for the length check
    always_comb begin
        next_hold_age = (st == ST_RD_STRETCH && !SCL_OE_N) ? hold_age + 13'h0001 : 13'h0000;
    end

    // Stretch age register
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hold_age <= 13'h0000;
        end else begin
            hold_age <= next_hold_age;
        end
    end

    chk_stretch_end : assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        hold_age <= 13'(`STRETCH_CYC))
        else $error("stretch lasted too long");
    chk_ptr_incr : assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (st == ST_RD_ACK && acked && scl_fall && !start_seen && !stop_seen)
        |=> ptr == 6'($past(ptr) + 6'h01))
        else $error("pointer did not advance");
    chk_ptr_load : assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (st == ST_WR_BYTE && first_wr && scl_fall && cnt == `BIT_LAST
        && !start_seen && !stop_seen) |=> (ptr == $past(shreg[5:0]) && !SDA_OE_N))
        else $error("first write byte not taken as pointer");
    chk_nak_release : assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        (st == ST_RD_ACK && !acked && scl_fall && !start_seen && !stop_seen)
        |=> (SDA_OE_N && st == ST_IDLE) [*2])
        else $error("data not released after not-acknowledge");
    chk_data_low_clk : assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        ($changed(sda_drv) && $past(st) != ST_IDLE && !$past(start_seen)
        && !$past(stop_seen)) |-> !$past(scl_s))
        else $error("data changed while clock high");
endmodule

// >>> thermo_port_cfg.svh
// Purpose: constants of the two-wire target port
// Assumes: REF_CLK at 50 MHz
// Notes: times are in ns, cycle counts derive from them
`ifndef THERMO_PORT_CFG_SVH
`define THERMO_PORT_CFG_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_NS 20
`define STRETCH_NS 60000
`define STRETCH_CYC ((`STRETCH_NS + `CLK_NS - 1) / `CLK_NS)
`define SETUP_NS 250
`define SETUP_CYC ((`SETUP_NS + `CLK_NS - 1) / `CLK_NS)

// ----------------------------------------
// Address, pointer and buffer layout
// ----------------------------------------
`define ADDR_FIXED 4'hc
`define PTR_W 6
`define PTR_RESET 6'h00
`define FIFO_W 14
`define FIFO_D 16
`define BIT_LAST 4'h8

`endif

// >>> thermo_port_pkg.sv
// Purpose: types of the two-wire target port
// Assumes: nothing
// Notes: state codes written out
package thermo_port_pkg;

    // ----------------------------------------
    // Port states
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_WR_BYTE = 4'h3,
        ST_WR_WAIT = 4'h4,
        ST_WR_ACK = 4'h5,
        ST_RD_STRETCH = 4'h6,
        ST_RD_BYTE = 4'h7,
        ST_RD_ACK = 4'h8
    } port_state_t;

endpackage

// >>> byte_fifo.sv
// Purpose: buffer between received bytes and the register file
// Assumes: single clock, depth a power of two
// Notes: extra pointer bit tells full from empty
`timescale 1ns/10ps
module byte_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic [AW:0] next_wp;
    logic [AW:0] next_rp;
    logic push;
    logic pop;

    // ----------------------------------------
    // Flags and pointer steps
    // ----------------------------------------
    always_comb begin
        in_ready = (wp[AW] == rp[AW]) || (wp[AW-1:0] != rp[AW-1:0]);
        out_valid = (wp != rp);
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wp = push ? wp + 1'b1 : wp;
        next_rp = pop ? rp + 1'b1 : rp;
        out_data = mem[rp[AW-1:0]];
    end

    // Pointer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
        end
    end

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end

    chk_full_refuse : assert property (@(posedge clk) disable iff (!rst_n)
        (wp[AW] != rp[AW] && wp[AW-1:0] == rp[AW-1:0]) |-> !in_ready)
        else $error("fifo accepts while full");
endmodule

// >>> i2c_ctl_model.sv
// Purpose: two-wire bus controller facing the target port
// Assumes: open-drain wires resolved by the bench
// Notes: moves its lines just after clock edges only
`timescale 1ns/10ps
module i2c_ctl_model #(
    parameter int H = 20
) (
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_drv,
    output logic sda_drv,
    output int tmo
);
    // Idle bus, both lines released
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
        tmo = 0;
    end

    // Wait whole clock cycles
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Release the clock, wait out a stretch, bounded
    task automatic rise();
        scl_drv <= 1'b1;
        hold(1);
        for (int i = 0; i < 5000 && !scl; i++) begin
            hold(1);
        end
        if (!scl) begin
            tmo++;
        end
        hold(H);
    endtask

    // One bit: data set mid low, sampled late in high
    task automatic bit_io(input logic b, output logic r);
        hold(H / 2);
        sda_drv <= b;
        hold(H / 2);
        rise();
        r = sda;
        scl_drv <= 1'b0;
    endtask

    // Start, also repeated start from clock low
    task automatic start();
        hold(H / 2);
        sda_drv <= 1'b1;
        hold(H / 2);
        rise();
        sda_drv <= 1'b0;
        hold(H);
        scl_drv <= 1'b0;
    endtask

    // Stop, then bus-free time
    task automatic stop();
        hold(H / 2);
        sda_drv <= 1'b0;
        hold(H / 2);
        rise();
        sda_drv <= 1'b1;
        hold(4 * H);
    endtask

    // Send nb bits of a byte, then take the acknowledge only when nb is 8
    task automatic send(input logic [7:0] d, input int nb, output logic nak);
        logic r;
        nak = 1'b1;
        for (int i = 7; i > 7 - nb; i--) begin
            bit_io(d[i], r);
        end
        if (nb == 8) begin
            bit_io(1'b1, nak);
        end
    endtask

    // Read a byte, then answer ack or nak
    task automatic recv(input logic nak, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nak, r);
    endtask
endmodule

// >>> thermo_sensor_i2c_slave_port_tb_top.sv
// Purpose: self-checking bench of the two-wire target port
// Assumes: 50 MHz clock, controller model on the wires
// Notes: reference tracks pointer, last sent byte and written words
`timescale 1ns/10ps
`include "thermo_port_cfg.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
    $display("Error %0t: got %h expected %h", $time, a, b); end end
module thermo_sensor_i2c_slave_port_tb_top
    import thermo_port_pkg::*;
;
    logic clk, arst_n, rd_valid, wr_ready, push, stall, fetch_on;
    logic scl_drv, sda_drv, scl, sda, sda_q, scl_out, sda_out;
    logic scl_oe_n, sda_oe_n, rd_req, wr_valid, busy;
    logic [2:0] addr_lvl;
    logic [5:0] rd_ptr, wr_ptr;
    logic [7:0] rd_data, wr_data, m_last;
    logic [13:0] w;
    logic [13:0] exp_wr[$];
    logic [31:0] seed;
    int err_count, cmp_count, m_ptr, ctl_tmo, cyc, low_run, last_run;

    // Open-drain wires, push lets the clock rise early
    assign scl = scl_drv & (scl_oe_n | scl_out | push);
    assign sda = sda_drv & (sda_oe_n | sda_out);

    always #10 clk = ~clk;

    thermo_sensor_i2c_slave_port dut (
        .REF_CLK(clk), .ARST_N(arst_n), .SCL_IN(scl), .SCL_OUT(scl_out),
        .SCL_OE_N(scl_oe_n), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
        .ADDR_LEVEL(addr_lvl), .RD_REQ(rd_req), .RD_PTR(rd_ptr),
        .RD_DATA(rd_data), .RD_VALID(rd_valid), .WR_VALID(wr_valid),
        .WR_READY(wr_ready), .WR_PTR(wr_ptr), .WR_DATA(wr_data), .BUSY(busy)
    );

    i2c_ctl_model ctl (
        .clk(clk), .scl(scl), .sda(sda), .scl_drv(scl_drv),
        .sda_drv(sda_drv), .tmo(ctl_tmo)
    );

    // Random source and register contents
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] reg_val(input int p);
        return 8'(p * 29 + 7);
    endfunction

    // Verdict and end of run
    task automatic conclude();
        if (ctl_tmo != 0) begin
            err_count++;
            $display("Error %0t: clock held too long", $time);
        end
        if (err_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Fetch answers, random consumer, stretch length, data stability
    always @(posedge clk) begin
        rd_valid <= rd_req && fetch_on;
        rd_data <= reg_val(int'(rd_ptr));
        seed = xs(seed);
        wr_ready <= !stall && seed[0];
        if (wr_valid === 1'b1 && wr_ready) begin
            w = exp_wr.pop_front();
            `CHK({wr_ptr, wr_data}, w)
        end
        if (arst_n && !push && scl) begin
            `CHK(sda_oe_n, sda_q)
        end
        sda_q <= sda_oe_n;
        low_run <= scl_oe_n ? 0 : low_run + 1;
        if (scl_oe_n && low_run != 0) begin
            last_run <= low_run;
        end
        cyc++;
        if (cyc == 90000) begin
            err_count++;
            $display("Error %0t: run too long", $time);
            conclude();
        end
    end

    // Address byte with expected acknowledge
    task automatic addr(input logic [6:0] a, input logic rw, input logic exp_nak);
        logic nak;
        ctl.start();
        ctl.send({a, rw}, 8, nak);
        `CHK(nak, exp_nak)
    endtask

    // Pointer byte, then n data bytes
    task automatic wr_seq(input logic [7:0] p, input int n);
        logic nak;
        logic [7:0] d;
        addr({4'hc, addr_lvl}, 1'b0, 1'b0);
        ctl.send(p, 8, nak);
        `CHK(nak, 1'b0)
        `CHK(rd_ptr, p[5:0])
        m_ptr = int'(p[5:0]);
        for (int i = 0; i < n; i++) begin
            seed = xs(seed);
            d = seed[7:0];
            exp_wr.push_back({p[5:0], d});
            ctl.send(d, 8, nak);
            `CHK(nak, 1'b0)
        end
        ctl.stop();
    endtask

    // Read n bytes, nak on the last
    task automatic rd_seq(input int n);
        logic [7:0] d;
        logic [7:0] e;
        addr({4'hc, addr_lvl}, 1'b1, 1'b0);
        for (int i = 0; i < n; i++) begin
            e = (fetch_on && !push) ? reg_val(m_ptr) : m_last;
            ctl.recv(i == n - 1, d);
            `CHK(d, e)
            m_last = e;
            if (i < n - 1) begin
                m_ptr = (m_ptr + 1) % 64;
            end
        end
        ctl.stop();
        `CHK(sda_oe_n, 1'b1)
        `CHK(scl_oe_n, 1'b1)
        `CHK(rd_ptr, 6'(m_ptr))
    endtask

    // Main sequence
    initial begin
        logic nak;
        clk = 1'b0;
        arst_n = 1'b0;
        addr_lvl = 3'h0;
        rd_data = 8'h00;
        rd_valid = 1'b0;
        wr_ready = 1'b0;
        {push, stall, fetch_on, sda_q} = 4'h3;
        seed = 34;
        m_last = 8'hff;
        {err_count, cmp_count, m_ptr, cyc, low_run, last_run} = '0;
        repeat (6) @(posedge clk);
        `CHK(sda_oe_n, 1'b1)
        `CHK(scl_oe_n, 1'b1)
        `CHK(busy, 1'b0)
        `CHK({scl_out, sda_out}, 2'h0)
        arst_n <= 1'b1;
        ctl.hold(4);
        for (int l = 0; l < 8; l++) begin
            addr_lvl <= 3'(l);
            ctl.hold(4);
            addr({4'hc, 3'(l)}, 1'b0, 1'b0);
            ctl.stop();
            addr({4'hc, 3'(l ^ 5)}, 1'b1, 1'b1);
            ctl.stop();
            addr({4'h4, 3'(l)}, 1'b0, 1'b1);
            ctl.stop();
        end
        ctl.start();
        ctl.send(8'hce, 4, nak);
        wr_seq(8'hc5, 3);
        rd_seq(3);
        `CHK(last_run, `STRETCH_CYC)
        rd_seq(2);
        wr_seq(8'h3f, 0);
        rd_seq(2);
        wr_seq(8'h20, 0);
        fetch_on <= 1'b0;
        rd_seq(1);
        fetch_on <= 1'b1;
        push <= 1'b1;
        rd_seq(1);
        push <= 1'b0;
        addr({4'hc, addr_lvl}, 1'b0, 1'b0);
        ctl.send(8'h0a, 8, nak);
        ctl.send(8'hff, 3, nak);
        ctl.stop();
        `CHK(busy, 1'b0)
        `CHK(sda_oe_n, 1'b1)
        `CHK(rd_ptr, 6'h0a)
        stall <= 1'b1;
        fork
            wr_seq(8'h11, 17);
            begin
                for (int i = 0; i < 12000; i++) begin
                    if (exp_wr.size() == 17 && scl_oe_n === 1'b0) begin
                        break;
                    end
                    ctl.hold(1);
                end
                ctl.hold(200);
                `CHK(scl_oe_n, 1'b0)
                `CHK(wr_valid, 1'b1)
                stall <= 1'b0;
            end
        join
        for (int i = 0; i < 2000 && exp_wr.size() != 0; i++) begin
            ctl.hold(1);
        end
        ctl.hold(2);
        `CHK(wr_valid, 1'b0)
        conclude();
    end
endmodule
